// >>> logic/timer3_pkg.sv
// Constants, register map and mode encoding of the third timer/counter
package timer3_pkg;

  // ************************************************************
  // Bus widths and answers
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MATCH = 8'h04;
  localparam logic [7:0] OFF_FLOP = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_START_POS = 2;
  localparam int STAT_EVENT_POS = 0;
  localparam logic [7:0] MATCH_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic FLOP_RST = 1'h0;
  localparam logic STATUS_RST = 1'h0;
  localparam logic MASK_RST = 1'h0;

  // ************************************************************
  // Operating modes
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_COUNTER = 2'b01,
    MODE_DIVIDER = 2'b10,
    MODE_PWM = 2'b11
  } mode_t;

  // Address is one of the mapped, word-aligned registers
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == OFF_CTRL) || (addr == OFF_MATCH) || (addr == OFF_FLOP) ||
                (addr == OFF_COUNT) || (addr == OFF_STATUS) || (addr == OFF_MASK);
  endfunction

endpackage

// >>> logic/edge_sync.sv
// Two-flop synchroniser with rising-edge detector for the count pin
module edge_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pin_in,
  output logic rise
);

  logic stage1;
  logic stage2;
  logic stage3;

  // Synchroniser chain; only stage2 reads stage1
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // One-cycle pulse per rising edge on the pin
  assign rise = stage2 & ~stage3;

endmodule

// >>> logic/match_buffer.sv
// Second stage of the match value, used while generating PWM
module match_buffer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] buffered,
  input wire logic first_load,
  input wire logic period_end,
  output logic [7:0] active
);

  // Copy on start and at each period end only, so duty never glitches
  always_ff @(posedge clk) begin
    if (!rstn) begin
      active <= timer3_pkg::MATCH_RST;
    end else if (first_load || period_end) begin
      active <= buffered;
    end
  end

endmodule

// >>> logic/timer3_top.sv
// Third timer/counter: timer, event counter, divider and PWM with AXI4-Lite registers
//
// Overview of operation
// - Timer mode: count clock, interrupt, clear on match
// - Counter mode: count external pin rising edges
// - After match clear, keep counting from zero
// - Divider mode: toggle flop, clear on match
// - Divider pin shows inverted flop, 50% duty
// - Flop resets to zero, software may load
// - Divider mode: interrupt on every pin toggle
// - PWM: toggle on match, no clear
// - PWM: toggle again on overflow, then clear
// - PWM pin shows inverted flop
// - PWM: interrupt on every overflow
// - PWM match double buffered, updates per period
// - Setting start bit loads first active match
// - Keeps counting and interrupting during sleep
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
module timer3_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_count_pin,
  output logic divider_out_pin,
  output logic pwm_out_pin,
  output logic irq
);

  // ************************************************************
  // Declarations
  // ************************************************************
  timer3_pkg::mode_t mode;
  logic timer_start_bit;
  logic [7:0] match_value_reg;
  logic [7:0] active_match;
  logic [7:0] count;
  logic flop;
  logic status;
  logic mask;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_lane0;
  logic ext_rise;
  logic tick;
  logic [7:0] cmp_value;
  logic hit;
  logic wrap;
  logic tc_event;
  logic first_load;
  logic flop_wr;
  logic next_flop;
  logic [7:0] next_count;

  // ************************************************************
  // External pin and PWM buffer
  // ************************************************************
  edge_sync u_edge_sync (
    .clk(clk),
    .rstn(rstn),
    .pin_in(ext_count_pin),
    .rise(ext_rise)
  );

  match_buffer u_match_buffer (
    .clk(clk),
    .rstn(rstn),
    .buffered(match_value_reg),
    .first_load(first_load),
    .period_end(wrap),
    .active(active_match)
  );

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  // Address and data are taken in either order, then answered together
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_lane0 = wr_fire && w_strb[0];

  // Write address holding
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data holding
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_wready <= 1'b1;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response, error on an unmapped address
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= timer3_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= timer3_pkg::is_mapped(aw_addr) ? timer3_pkg::RESP_OKAY
                                                    : timer3_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  // One read at a time; data registered with the valid
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= timer3_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= timer3_pkg::is_mapped(s_axi_araddr) ? timer3_pkg::RESP_OKAY
                                                         : timer3_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        timer3_pkg::OFF_CTRL: s_axi_rdata <= {29'h0, timer_start_bit, mode};
        timer3_pkg::OFF_MATCH: s_axi_rdata <= {24'h0, match_value_reg};
        timer3_pkg::OFF_FLOP: s_axi_rdata <= {31'h0, flop};
        timer3_pkg::OFF_COUNT: s_axi_rdata <= {24'h0, count};
        timer3_pkg::OFF_STATUS: s_axi_rdata <= {31'h0, status};
        timer3_pkg::OFF_MASK: s_axi_rdata <= {31'h0, mask};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  // Start bit rising by software makes the first buffer transfer
  assign first_load = wr_lane0 && (aw_addr == timer3_pkg::OFF_CTRL) && !timer_start_bit &&
                      w_data[timer3_pkg::CTRL_START_POS];
  assign flop_wr = wr_lane0 && (aw_addr == timer3_pkg::OFF_FLOP);

  // Mode field and start bit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode <= timer3_pkg::MODE_TIMER;
      timer_start_bit <= 1'b0;
    end else if (wr_lane0 && aw_addr == timer3_pkg::OFF_CTRL) begin
      mode <= timer3_pkg::mode_t'(w_data[timer3_pkg::CTRL_MODE_LSB +: 2]);
      timer_start_bit <= w_data[timer3_pkg::CTRL_START_POS];
    end
  end

  // Match value (first stage in PWM mode) and interrupt mask
  always_ff @(posedge clk) begin
    if (!rstn) begin
      match_value_reg <= timer3_pkg::MATCH_RST;
      mask <= timer3_pkg::MASK_RST;
    end else begin
      if (wr_lane0 && aw_addr == timer3_pkg::OFF_MATCH) begin
        match_value_reg <= w_data[7:0];
      end
      if (wr_lane0 && aw_addr == timer3_pkg::OFF_MASK) begin
        mask <= w_data[timer3_pkg::STAT_EVENT_POS];
      end
    end
  end

  // ************************************************************
  // Counting engine
  // ************************************************************
  // No sleep gating: the engine runs whenever the clock runs and the start bit is set
  assign tick = timer_start_bit && ((mode == timer3_pkg::MODE_COUNTER) ? ext_rise
                                                                       : 1'b1);
  assign cmp_value = (mode == timer3_pkg::MODE_PWM) ? active_match : match_value_reg;
  assign hit = tick && (count == cmp_value);
  assign wrap = tick && (mode == timer3_pkg::MODE_PWM) && (count == timer3_pkg::COUNT_MAX);
  assign tc_event = (mode == timer3_pkg::MODE_PWM) ? wrap : hit;

  // Next counter and flop values per mode
  always_comb begin
    next_count = count;
    next_flop = flop;
    if (mode == timer3_pkg::MODE_PWM) begin
      next_flop = flop ^ hit ^ wrap;
      if (tick) begin
        next_count = count + 8'h01;
      end
    end else if (hit) begin
      next_count = timer3_pkg::COUNT_RST;
      if (mode == timer3_pkg::MODE_DIVIDER) begin
        next_flop = ~flop;
      end
    end else if (tick) begin
      next_count = count + 8'h01;
    end
    if (flop_wr) begin
      next_flop = w_data[0];
    end
  end

  // Counter, flop and output pins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      count <= timer3_pkg::COUNT_RST;
      flop <= timer3_pkg::FLOP_RST;
      divider_out_pin <= 1'b1;
      pwm_out_pin <= 1'b1;
    end else begin
      count <= next_count;
      flop <= next_flop;
      divider_out_pin <= (mode == timer3_pkg::MODE_DIVIDER) ? ~flop : 1'b1;
      pwm_out_pin <= (mode == timer3_pkg::MODE_PWM) ? ~flop : 1'b1;
    end
  end

  // ************************************************************
  // Interrupt status and output
  // ************************************************************
  // Write one clears; a new event in the same cycle wins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      status <= timer3_pkg::STATUS_RST;
      irq <= 1'b0;
    end else begin
      if (tc_event) begin
        status <= 1'b1;
      end else if (wr_lane0 && aw_addr == timer3_pkg::OFF_STATUS &&
                   w_data[timer3_pkg::STAT_EVENT_POS]) begin
        status <= 1'b0;
      end
      irq <= status && mask;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_match_hit(timer3_pkg::mode_t m);
    mode == m && hit && !flop_wr;
  endsequence

  sequence s_pwm_wrap;
    mode == timer3_pkg::MODE_PWM && wrap && !flop_wr;
  endsequence

  a_timer_match_clear: assert property (@(posedge clk) disable iff (!rstn)
    s_match_hit(timer3_pkg::MODE_TIMER) |=> count == 8'h00 && status)
    else $error("timer match did not clear counter or flag event");

  a_counter_pin_only: assert property (@(posedge clk) disable iff (!rstn)
    mode == timer3_pkg::MODE_COUNTER && !ext_rise |=> count == $past(count))
    else $error("counter mode advanced without a pin edge");

  a_count_resumes: assert property (@(posedge clk) disable iff (!rstn)
    s_match_hit(timer3_pkg::MODE_TIMER) ##1 (tick && count != match_value_reg)
    |=> count == 8'h01)
    else $error("counter did not resume from zero");

  a_divider_toggle: assert property (@(posedge clk) disable iff (!rstn)
    s_match_hit(timer3_pkg::MODE_DIVIDER) |=> flop != $past(flop) && count == 8'h00 && status)
    else $error("divider match did not toggle and clear");

  a_divider_pin: assert property (@(posedge clk) disable iff (!rstn)
    mode == timer3_pkg::MODE_DIVIDER ##1 mode == timer3_pkg::MODE_DIVIDER
    |-> divider_out_pin == !$past(flop))
    else $error("divider pin is not the inverted flop");

  a_flop_reset: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> flop == 1'b0 && divider_out_pin && pwm_out_pin)
    else $error("flop not zero after reset");

  a_pwm_match_keep: assert property (@(posedge clk) disable iff (!rstn)
    s_match_hit(timer3_pkg::MODE_PWM) && !wrap |=> count == $past(count) + 8'h01)
    else $error("pwm match cleared the counter");

  a_pwm_wrap: assert property (@(posedge clk) disable iff (!rstn)
    s_pwm_wrap and (count != active_match) |=> count == 8'h00 && flop != $past(flop) && status)
    else $error("pwm overflow did not toggle, clear and flag");

  a_pwm_pin: assert property (@(posedge clk) disable iff (!rstn)
    mode == timer3_pkg::MODE_PWM ##1 mode == timer3_pkg::MODE_PWM
    |-> pwm_out_pin == !$past(flop))
    else $error("pwm pin is not the inverted flop");

  a_pwm_buffer_hold: assert property (@(posedge clk) disable iff (!rstn)
    !wrap && !first_load |=> $stable(active_match))
    else $error("active match changed mid period");

  a_start_first_load: assert property (@(posedge clk) disable iff (!rstn)
    first_load |=> timer_start_bit && active_match == $past(match_value_reg))
    else $error("start did not load active match");

  a_irq_follows: assert property (@(posedge clk) disable iff (!rstn)
    s_pwm_wrap ##1 mask |=> irq)
    else $error("unmasked event did not raise irq");

  a_divider_event: assert property (@(posedge clk) disable iff (!rstn)
    s_match_hit(timer3_pkg::MODE_DIVIDER) ##1 mode == timer3_pkg::MODE_DIVIDER
    |-> status ##1 divider_out_pin != $past(divider_out_pin))
    else $error("divider toggle did not flag event");

  a_irq_raise: assert property (@(posedge clk) disable iff (!rstn)
    status && mask |=> irq)
    else $error("unmasked status did not raise irq");

  a_irq_quiet: assert property (@(posedge clk) disable iff (!rstn)
    !(status && mask) |=> !irq)
    else $error("irq high without unmasked status");

endmodule

// >>> dv/ext_pin_model.sv
// Far-side model: source of count pulses on the external count pin
module ext_pin_model (
  input wire logic clk,
  output logic ext_count_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // ************************************************************
  // Pin idles low between pulses
  // ************************************************************
  initial begin
    ext_count_pin = 1'b0;
  end

  // Each pulse is high and low for four clocks, slow enough to synchronise
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      ext_count_pin <= 1'b1;
      repeat (4) @(posedge clk);
      ext_count_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

// >>> dv/timer3_match_divider_pwm_tb.sv
// Self-checking testbench of the third timer/counter
module timer3_match_divider_pwm_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ************************************************************
  // Signals
  // ************************************************************
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, ext_pin, div_pin, pwm_pin, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;

  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  timer3_top u_timer3_top (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_count_pin(ext_pin), .divider_out_pin(div_pin), .pwm_out_pin(pwm_pin), .irq(irq));

  ext_pin_model u_ext_pin_model (.clk(clk), .ext_count_pin(ext_pin));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Write one word; address and data are released each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Write expecting OKAY, and read compared against an expected word
  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check("write response", {30'h0, r}, {30'h0, timer3_pkg::RESP_OKAY});
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(nm, d, exp);
  endtask

  function automatic logic [31:0] ctl(input timer3_pkg::mode_t m, input logic s);
    return {29'h0, s, m};
  endfunction

  // Waits for a pin level, then counts clocks while it holds
  task automatic measure(input bit use_pwm, input logic lvl, output int len);
    int n;
    n = 0;
    while ((use_pwm ? pwm_pin : div_pin) !== lvl && n < 2000) begin
      @(posedge clk);
      n++;
    end
    len = 0;
    while ((use_pwm ? pwm_pin : div_pin) === lvl && len < 2000) begin
      @(posedge clk);
      len++;
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset_and_bus();
    logic [31:0] d;
    logic [1:0] r;
    rchk("ctrl reset", timer3_pkg::OFF_CTRL, 32'h0);
    rchk("match reset", timer3_pkg::OFF_MATCH, 32'h0);
    rchk("flop reset", timer3_pkg::OFF_FLOP, 32'h0);
    rchk("count reset", timer3_pkg::OFF_COUNT, 32'h0);
    rchk("status reset", timer3_pkg::OFF_STATUS, 32'h0);
    rchk("mask reset", timer3_pkg::OFF_MASK, 32'h0);
    wr(8'h18, 32'h1, r);
    check("unmapped write", {30'h0, r}, {30'h0, timer3_pkg::RESP_SLVERR});
    rd(8'h1C, d, r);
    check("unmapped read", {30'h0, r}, {30'h0, timer3_pkg::RESP_SLVERR});
    check("unmapped data", d, 32'h0);
    // A write without lane 0 is answered but changes nothing
    wstrb <= 4'h0;
    wok(timer3_pkg::OFF_MATCH, 32'h55);
    wstrb <= 4'hF;
    rchk("lane off write", timer3_pkg::OFF_MATCH, 32'h0);
  endtask

  task automatic t_timer();
    int t0;
    wok(timer3_pkg::OFF_MATCH, 32'h9);
    wok(timer3_pkg::OFF_CTRL, ctl(timer3_pkg::MODE_TIMER, 1'b1));
    repeat (20) @(posedge clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    rchk("status set", timer3_pkg::OFF_STATUS, 32'h1);
    wok(timer3_pkg::OFF_MASK, 32'h1);
    repeat (3) @(posedge clk);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    wok(timer3_pkg::OFF_STATUS, 32'h1);
    do @(posedge clk); while (!irq);
    t0 = cyc;
    wok(timer3_pkg::OFF_STATUS, 32'h1);
    do @(posedge clk); while (!irq);
    check("timer period", cyc - t0, 32'd10);
  endtask

  task automatic t_counter();
    wok(timer3_pkg::OFF_MATCH, 32'h0);
    repeat (300) @(posedge clk);
    wok(timer3_pkg::OFF_CTRL, ctl(timer3_pkg::MODE_COUNTER, 1'b1));
    wok(timer3_pkg::OFF_MATCH, 32'h2);
    wok(timer3_pkg::OFF_STATUS, 32'h1);
    u_ext_pin_model.pulse(2);
    rchk("count two edges", timer3_pkg::OFF_COUNT, 32'h2);
    rchk("no event yet", timer3_pkg::OFF_STATUS, 32'h0);
    u_ext_pin_model.pulse(1);
    rchk("count cleared", timer3_pkg::OFF_COUNT, 32'h0);
    rchk("counter event", timer3_pkg::OFF_STATUS, 32'h1);
    u_ext_pin_model.pulse(1);
    rchk("count resumes", timer3_pkg::OFF_COUNT, 32'h1);
  endtask

  task automatic t_divider();
    int len;
    wok(timer3_pkg::OFF_CTRL, ctl(timer3_pkg::MODE_DIVIDER, 1'b0));
    wok(timer3_pkg::OFF_FLOP, 32'h1);
    repeat (2) @(posedge clk);
    check("loaded flop pin", {31'h0, div_pin}, 32'h0);
    rchk("flop readback", timer3_pkg::OFF_FLOP, 32'h1);
    wok(timer3_pkg::OFF_FLOP, 32'h0);
    wok(timer3_pkg::OFF_MATCH, 32'h4);
    wok(timer3_pkg::OFF_STATUS, 32'h1);
    wok(timer3_pkg::OFF_CTRL, ctl(timer3_pkg::MODE_DIVIDER, 1'b1));
    measure(1'b0, 1'b0, len);
    check("divider low", len, 32'd5);
    measure(1'b0, 1'b1, len);
    check("divider high", len, 32'd5);
    rchk("divider event", timer3_pkg::OFF_STATUS, 32'h1);
  endtask

  task automatic t_pwm();
    int len;
    wok(timer3_pkg::OFF_CTRL, ctl(timer3_pkg::MODE_PWM, 1'b0));
    wok(timer3_pkg::OFF_FLOP, 32'h0);
    wok(timer3_pkg::OFF_MATCH, 32'h40);
    wok(timer3_pkg::OFF_CTRL, ctl(timer3_pkg::MODE_PWM, 1'b1));
    measure(1'b1, 1'b0, len);
    check("pwm first low", len, 32'd191);
    wok(timer3_pkg::OFF_STATUS, 32'h1);
    wok(timer3_pkg::OFF_MATCH, 32'h80);
    measure(1'b1, 1'b0, len);
    check("pwm old duty kept", len, 32'd191);
    measure(1'b1, 1'b0, len);
    check("pwm new duty", len, 32'd127);
    rchk("pwm overflow event", timer3_pkg::OFF_STATUS, 32'h1);
    check("pwm irq", {31'h0, irq}, 32'h1);
  endtask

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset_and_bus();
    t_timer();
    t_counter();
    t_divider();
    t_pwm();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim();
  end
endmodule
